// ===== hdl/cdr_top.sv
// Reflectometry result capture and receiver variance logic
//
// How it works
// - Samples count only between window start and stop times, 8 ns steps.
// - Six-bit peak holds largest sample, or smallest when minimum select set.
// - Peak time records first occurrence; equal later samples do not move it.
// - Results valid only once busy reads clear after the pulse.
// - Threshold-met flag sets when any window sample went strictly beyond the threshold.
// - Threshold time holds first sample strictly beyond threshold, valid with flag.
// - Reserved bits ignore writes and read as zero.
// - Ready flag sets on new result, clears after two data reads.
// - Writing bit 5 loads accumulator top byte from test data.
// - Writing bit 4 loads accumulator second byte from test data.
// - Freeze holds the data register; clears after two data reads.
// - Timer field selects 2, 4, 6 or 8 units of period.
// - New timer value restarts computation; result loads when period ends.
// - Computation runs only while enable set; enable resets to zero.
// - Data register returns low half first, then high half.
// - Data register contents valid only while ready is set.
// - Samples are six-bit codes, 0x00 to 0x3f, midpoint 0x20.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module cdr_top #(
   parameter int unsigned P_UNIT_CYC = cdr_pkg::UNIT_CYC
) (
   input  wire logic        i_clk,        // 100 MHz clock
   input  wire logic        i_rst_n,      // Sync reset, active low
   input  wire logic        i_hsel,       // AHB select
   input  wire logic [31:0] i_haddr,      // AHB address
   input  wire logic [1:0]  i_htrans,     // AHB transfer type
   input  wire logic        i_hwrite,     // AHB write
   input  wire logic [2:0]  i_hsize,      // AHB size
   input  wire logic [31:0] i_hwdata,     // AHB write data
   input  wire logic        i_hready,     // AHB bus ready
   output logic [31:0]      o_hrdata,     // AHB read data
   output logic             o_hreadyout,  // AHB slave ready
   output logic             o_hresp,      // AHB response
   input  wire logic        i_pulse_start,// Pulse sent, one cycle
   input  wire logic        i_smp_vld,    // Reflection sample valid
   input  wire logic [5:0]  i_smp,        // Reflection sample code
   input  wire logic        i_var_vld,    // Variance term valid
   input  wire logic [15:0] i_var_term    // Squared error term
);

   // ------------------------------------------------------------
   // Bus front end
   // ------------------------------------------------------------
   cdr_pkg::cdr_req_s req;
   logic [15:0]       rdata;

   cdr_ahb_slave cdr_ahb_slave_inst (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_hsel      (i_hsel),
      .i_haddr     (i_haddr),
      .i_htrans    (i_htrans),
      .i_hwrite    (i_hwrite),
      .i_hsize     (i_hsize),
      .i_hwdata    (i_hwdata),
      .i_hready    (i_hready),
      .i_rdata     (rdata),
      .o_hrdata    (o_hrdata),
      .o_hreadyout (o_hreadyout),
      .o_hresp     (o_hresp),
      .o_req       (req)
   );

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic win_wr;
   logic ctrl_wr;
   logic tdat_wr;
   logic vctl_wr;
   logic vdat_rd;
   logic vdat_second;

   assign win_wr      = req.wr && (req.idx == cdr_pkg::IDX_WIN);
   assign ctrl_wr     = req.wr && (req.idx == cdr_pkg::IDX_CTRL);
   assign tdat_wr     = req.wr && (req.idx == cdr_pkg::IDX_TDAT);
   assign vctl_wr     = req.wr && (req.idx == cdr_pkg::IDX_VCTL);
   assign vdat_rd     = req.rd && (req.idx == cdr_pkg::IDX_VDAT);

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0]  window_start_time;
   logic [7:0]  window_stop_time;
   logic        min_mode;
   logic [5:0]  thr_level;
   logic [15:0] test_data_value;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         window_start_time <= cdr_pkg::WIN_RST[15:8];
         window_stop_time  <= cdr_pkg::WIN_RST[7:0];
      end else if (win_wr) begin
         window_start_time <= req.wdata[cdr_pkg::WIN_START_LSB +: 8];
         window_stop_time  <= req.wdata[cdr_pkg::WIN_STOP_LSB +: 8];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         min_mode  <= 1'b0;
         thr_level <= cdr_pkg::SMP_MID;
      end else if (ctrl_wr) begin
         min_mode  <= req.wdata[cdr_pkg::CTRL_MIN];
         thr_level <= req.wdata[cdr_pkg::CTRL_THR_LSB +: 6];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         test_data_value <= cdr_pkg::TDAT_RST;
      end else if (tdat_wr) begin
         test_data_value <= req.wdata;
      end
   end

   // ------------------------------------------------------------
   // Reflectometry sequencing
   // ------------------------------------------------------------
   cdr_pkg::cdr_tdr_e tdr_state;
   logic [7:0]        smp_time;
   logic              in_win;
   logic              smp_take;
   logic              last_smp;

   assign in_win   = (smp_time >= window_start_time) &&
                     (smp_time <= window_stop_time);
   assign smp_take = (tdr_state == cdr_pkg::TDR_RUN) && i_smp_vld &&
                     !i_pulse_start;
   assign last_smp = (smp_time == window_stop_time) ||
                     (smp_time == cdr_pkg::TIME_LAST);

   // Busy until the window has been swept
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tdr_state <= cdr_pkg::TDR_IDLE;
      end else begin
         unique case (tdr_state)
            cdr_pkg::TDR_IDLE: begin
               if (i_pulse_start) begin
                  tdr_state <= cdr_pkg::TDR_RUN;
               end
            end
            cdr_pkg::TDR_RUN: begin
               if (smp_take && last_smp) begin
                  tdr_state <= cdr_pkg::TDR_IDLE;
               end
            end
         endcase
      end
   end

   // Sample time in 8 ns steps after the pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         smp_time <= 8'h00;
      end else if (i_pulse_start) begin
         smp_time <= 8'h00;
      end else if (smp_take) begin
         smp_time <= smp_time + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Peak capture
   // ------------------------------------------------------------
   logic       peak_seen;
   logic [5:0] peak_value;
   logic [7:0] peak_first_time;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         peak_seen       <= 1'b0;
         peak_value      <= 6'h00;
         peak_first_time <= 8'h00;
      end else if (i_pulse_start) begin
         peak_seen <= 1'b0;
      end else if (smp_take && in_win) begin
         // Strict compare keeps the first occurrence
         if (!peak_seen ||
             cdr_pkg::cdr_beyond(i_smp, peak_value, min_mode)) begin
            peak_seen       <= 1'b1;
            peak_value      <= i_smp;
            peak_first_time <= smp_time;
         end
      end
   end

   // ------------------------------------------------------------
   // Threshold capture
   // ------------------------------------------------------------
   logic       threshold_met_flag;
   logic [7:0] threshold_first_time;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         threshold_met_flag   <= 1'b0;
         threshold_first_time <= 8'h00;
      end else if (i_pulse_start) begin
         threshold_met_flag <= 1'b0;
      end else if (smp_take && in_win && !threshold_met_flag &&
                   cdr_pkg::cdr_beyond(i_smp, thr_level, min_mode)) begin
         threshold_met_flag   <= 1'b1;
         threshold_first_time <= smp_time;
      end
   end

   // ------------------------------------------------------------
   // Variance control
   // ------------------------------------------------------------
   logic        var_enable;
   logic [1:0]  var_timer;
   logic        var_freeze;
   logic        var_ready;
   logic        rd_high;
   logic        restart;
   logic [1:0]  new_timer;
   logic        new_enable;

   assign new_timer   = req.wdata[cdr_pkg::VC_TMR_LSB +: 2];
   assign new_enable  = req.wdata[cdr_pkg::VC_ENABLE];
   assign vdat_second = vdat_rd && rd_high;
   assign restart     = vctl_wr &&
                        ((new_timer != var_timer) ||
                         (new_enable && !var_enable));

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         var_enable <= 1'b0;
         var_timer  <= cdr_pkg::TMR_RST;
      end else if (vctl_wr) begin
         var_enable <= new_enable;
         var_timer  <= new_timer;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         var_freeze <= 1'b0;
      end else if (vctl_wr) begin
         var_freeze <= req.wdata[cdr_pkg::VC_FREEZE];
      end else if (vdat_second) begin
         var_freeze <= 1'b0;
      end
   end

   // Read half pointer, restarts on freeze or any other access
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_high <= 1'b0;
      end else if (vdat_rd) begin
         rd_high <= !rd_high;
      end else if (req.rd || req.wr) begin
         rd_high <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Variance period timer
   // ------------------------------------------------------------
   logic [16:0] unit_cnt;
   logic [3:0]  unit_num;
   logic [3:0]  period_units;
   logic        unit_end;
   logic        elapsed;

   assign period_units = ({2'b00, var_timer} + 4'h1) *
                         cdr_pkg::UNITS_PER_STEP;
   assign unit_end     = (unit_cnt == 17'(P_UNIT_CYC - 1));
   assign elapsed      = var_enable && !restart && unit_end &&
                         (unit_num == period_units - 4'h1);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         unit_cnt <= 17'h00000;
         unit_num <= 4'h0;
      end else if (!var_enable || restart) begin
         unit_cnt <= 17'h00000;
         unit_num <= 4'h0;
      end else if (unit_end) begin
         unit_cnt <= 17'h00000;
         unit_num <= elapsed ? 4'h0 : unit_num + 4'h1;
      end else begin
         unit_cnt <= unit_cnt + 17'h00001;
      end
   end

   // ------------------------------------------------------------
   // Variance accumulation and result
   // ------------------------------------------------------------
   logic [31:0] accum;
   logic [31:0] var_result;
   logic        load_hi;
   logic        load_lo;

   assign load_hi = vctl_wr && req.wdata[cdr_pkg::VC_LOAD_HI];
   assign load_lo = vctl_wr && req.wdata[cdr_pkg::VC_LOAD_LO];

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         accum <= 32'h00000000;
      end else if (load_hi || load_lo) begin
         if (load_hi) begin
            accum[31:24] <= test_data_value[7:0];
         end
         if (load_lo) begin
            accum[23:16] <= test_data_value[7:0];
         end
      end else if (!var_enable || restart || elapsed) begin
         accum <= 32'h00000000;
      end else if (i_var_vld) begin
         accum <= accum + {16'h0000, i_var_term};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         var_result <= 32'h00000000;
      end else if (elapsed && !var_freeze) begin
         var_result <= accum;
      end
   end

   // New result wins over the clearing read
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         var_ready <= 1'b0;
      end else if (elapsed && !var_freeze) begin
         var_ready <= 1'b1;
      end else if (vdat_second) begin
         var_ready <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read multiplexer, reserved bits zero
   // ------------------------------------------------------------
   logic busy;

   assign busy = (tdr_state == cdr_pkg::TDR_RUN);

   always_comb begin
      unique case (req.idx)
         cdr_pkg::IDX_CTRL:
            rdata = {4'h0, busy, 3'h0, min_mode, 1'b0, thr_level};
         cdr_pkg::IDX_WIN:
            rdata = {window_start_time, window_stop_time};
         cdr_pkg::IDX_PEAK:
            rdata = {2'b00, peak_value, peak_first_time};
         cdr_pkg::IDX_THR:
            rdata = {7'h00, threshold_met_flag,
                     threshold_first_time};
         cdr_pkg::IDX_VCTL:
            rdata = {var_ready, 11'h000, var_freeze, var_timer,
                     var_enable};
         cdr_pkg::IDX_VDAT:
            rdata = rd_high ? var_result[31:16]
                            : var_result[15:0];
         cdr_pkg::IDX_TDAT:
            rdata = test_data_value;
         default:
            rdata = 16'h0000;
      endcase
   end

endmodule // cdr_top

// ===== hdl/cdr_pkg.sv
// Shared constants, types and helpers for the cable diagnostic result logic
package cdr_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL = 6'h16;
   localparam logic [5:0] IDX_WIN  = 6'h17;
   localparam logic [5:0] IDX_PEAK = 6'h18;
   localparam logic [5:0] IDX_THR  = 6'h19;
   localparam logic [5:0] IDX_VCTL = 6'h1a;
   localparam logic [5:0] IDX_VDAT = 6'h1b;
   localparam logic [5:0] IDX_TDAT = 6'h1c;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int WIN_START_LSB = 8;
   localparam int WIN_STOP_LSB  = 0;
   localparam int CTRL_BUSY     = 11;
   localparam int CTRL_MIN      = 7;
   localparam int CTRL_THR_LSB  = 0;
   localparam int VC_READY      = 15;
   localparam int VC_LOAD_HI    = 5;
   localparam int VC_LOAD_LO    = 4;
   localparam int VC_FREEZE     = 3;
   localparam int VC_TMR_LSB    = 1;
   localparam int VC_ENABLE     = 0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] WIN_RST  = 16'h0000;
   localparam logic [15:0] TDAT_RST = 16'h0000;
   localparam logic [5:0]  SMP_MID  = 6'h20;
   localparam logic [1:0]  TMR_RST  = 2'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLK_PS  = 10000;
   localparam longint UNIT_PS = 1048576000;
   localparam int unsigned UNIT_CYC = int'(UNIT_PS / CLK_PS);
   localparam logic [3:0] UNITS_PER_STEP = 4'h2;
   localparam logic [7:0] TIME_LAST = 8'hff;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  idx;
      logic [15:0] wdata;
   } cdr_req_s;

   typedef enum logic {TDR_IDLE, TDR_RUN} cdr_tdr_e;

   // Sample lies beyond reference in the selected direction
   function automatic logic cdr_beyond(input logic [5:0] smp,
                                       input logic [5:0] ref_val,
                                       input logic       min_sel);
      return min_sel ? (smp < ref_val) : (smp > ref_val);
   endfunction

endpackage

// ===== hdl/cdr_ahb_slave.sv
// AHB-Lite slave front end for the diagnostic register file
`timescale 1ns/1ps
module cdr_ahb_slave (
   input  wire logic             i_clk,      // System clock
   input  wire logic             i_rst_n,    // Sync reset, active low
   input  wire logic             i_hsel,     // Slave select
   input  wire logic [31:0]      i_haddr,    // Byte address
   input  wire logic [1:0]       i_htrans,   // Transfer type
   input  wire logic             i_hwrite,   // Write when high
   input  wire logic [2:0]       i_hsize,    // Transfer size
   input  wire logic [31:0]      i_hwdata,   // Write data
   input  wire logic             i_hready,   // Bus ready
   input  wire logic [15:0]      i_rdata,    // Register read value
   output logic [31:0]           o_hrdata,   // Read data
   output logic                  o_hreadyout,// Slave ready
   output logic                  o_hresp,    // Always OKAY
   output cdr_pkg::cdr_req_s     o_req       // Register access strobe
);

   // ------------------------------------------------------------
   // Address phase capture
   // ------------------------------------------------------------
   logic       ph_wr;
   logic       ph_rd;
   logic [5:0] ph_idx;
   logic       take;

   assign take = i_hsel && i_hready && i_htrans[1];

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ph_wr  <= 1'b0;
         ph_rd  <= 1'b0;
         ph_idx <= 6'h00;
      end else begin
         ph_wr <= take && i_hwrite && (i_hsize == 3'h2);
         ph_rd <= take && !i_hwrite;
         if (take) begin
            ph_idx <= (i_haddr[31:8] == 24'h000000) ?
                      i_haddr[7:2] : 6'h3f;
         end
      end
   end

   // ------------------------------------------------------------
   // Data phase: reads take one wait state
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_hreadyout <= 1'b1;
         o_hrdata    <= 32'h00000000;
         o_hresp     <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
         if (take && !i_hwrite) begin
            o_hreadyout <= 1'b0;
         end else if (ph_rd) begin
            o_hreadyout <= 1'b1;
            o_hrdata    <= {16'h0000, i_rdata};
         end
      end
   end

   always_comb begin
      o_req.wr    = ph_wr;
      o_req.rd    = ph_rd;
      o_req.idx   = ph_idx;
      o_req.wdata = i_hwdata[15:0];
   end

endmodule // cdr_ahb_slave

// ===== testbench/cdr_top_asserts.sv
// Concurrent checks on the bus ports of the diagnostic result logic
`timescale 1ns/1ps
module cdr_top_asserts (
   input  wire logic        i_clk,        // Clock
   input  wire logic        i_rst_n,      // Sync reset, active low
   input  wire logic        i_hsel,       // AHB select
   input  wire logic [31:0] i_haddr,      // AHB address
   input  wire logic [1:0]  i_htrans,     // AHB transfer type
   input  wire logic        i_hwrite,     // AHB write
   input  wire logic        i_hready,     // AHB bus ready
   input  wire logic [31:0] o_hrdata,     // AHB read data
   input  wire logic        o_hreadyout,  // AHB slave ready
   input  wire logic        o_hresp,      // AHB response
   input  wire logic        i_pulse_start // Pulse sent
);
   // ----------------------------------------
   // Transfer decode
   // ----------------------------------------
   logic       go;
   logic       hit;
   logic [5:0] idx;
   assign go  = i_hsel && i_hready && i_htrans[1];
   assign hit = go && !i_hwrite && i_haddr[31:8] == 24'h0;
   assign idx = i_haddr[7:2];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_read_wait: assert property (
      go && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (go && i_hwrite |=> o_hreadyout)
      else $error("write stalled");
   a_resp_okay: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   a_upper_zero: assert property (o_hrdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_peak_rsvd: assert property (
      hit && idx == cdr_pkg::IDX_PEAK |-> ##2 o_hrdata[15:14] == 2'h0)
      else $error("peak reserved bits not zero");
   a_thr_rsvd: assert property (
      hit && idx == cdr_pkg::IDX_THR |-> ##2 o_hrdata[15:9] == 7'h0)
      else $error("threshold reserved bits not zero");
   a_vctl_rsvd: assert property (
      hit && idx == cdr_pkg::IDX_VCTL |-> ##2 o_hrdata[14:4] == 11'h0)
      else $error("variance control reserved bits not zero");
   a_unmapped_zero: assert property (
      go && !i_hwrite && i_haddr[31:8] != 24'h0 |-> ##2 o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_data_hold: assert property (
      o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
      else $error("read data moved outside read");

   c_data_read: cover property (hit && idx == cdr_pkg::IDX_VDAT);
   c_pulse: cover property (i_pulse_start);
   c_write: cover property (go && i_hwrite);
endmodule // cdr_top_asserts

// ===== testbench/testbench.sv
// Register-level bench for the diagnostic result logic
`timescale 1ns/1ps
module testbench;
   localparam int unsigned PU = 20;
   logic        i_clk;
   logic        i_rst_n;
   logic        i_hsel;
   logic [31:0] i_haddr;
   logic [1:0]  i_htrans;
   logic        i_hwrite;
   logic [31:0] i_hwdata;
   logic        i_hready;
   logic [31:0] o_hrdata;
   logic        o_hreadyout;
   logic        o_hresp;
   logic        i_pulse_start;
   logic        i_smp_vld;
   logic [5:0]  i_smp;
   logic        i_var_vld;
   logic [15:0] i_var_term;
   logic [31:0] rd_val;
   int          n_errors;
   int          samples_checked;
   int          cyc;
   int          t0;
   int          el;

   assign i_hready = o_hreadyout;

   cdr_top #(.P_UNIT_CYC(PU)) cdr_top_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(i_hready),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_pulse_start(i_pulse_start), .i_smp_vld(i_smp_vld),
      .i_smp(i_smp), .i_var_vld(i_var_vld), .i_var_term(i_var_term));

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [15:0] d);
      @(posedge i_clk);
      i_hsel   <= 1'b1;
      i_haddr  <= a;
      i_htrans <= 2'b10;
      i_hwrite <= w;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'b00;
      i_hwdata <= {16'h0, d};
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      rd_val = o_hrdata;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      bus(1'b1, {24'h0, idx, 2'b00}, d);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [15:0] e);
      bus(1'b0, {24'h0, idx, 2'b00}, 16'h0);
      chk(rd_val, {16'h0, e});
   endtask

   task automatic wait_rdy;
      rd_val = 32'h0;
      for (int n = 0; n < 300 && rd_val[15] !== 1'b1; n++)
         bus(1'b0, {24'h0, cdr_pkg::IDX_VCTL, 2'b00}, 16'h0);
   endtask

   // One pulse, busy check, then six samples at times 0 to 5
   task automatic shot(input logic [35:0] s, input logic [15:0] ctl);
      @(posedge i_clk);
      i_pulse_start <= 1'b1;
      @(posedge i_clk);
      i_pulse_start <= 1'b0;
      rd(cdr_pkg::IDX_CTRL, ctl | 16'h0800);
      for (int k = 0; k < 6; k++) begin
         i_smp_vld <= 1'b1;
         i_smp     <= s[35-6*k -: 6];
         @(posedge i_clk);
      end
      i_smp_vld <= 1'b0;
   endtask

   task automatic results;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   always @(posedge i_clk) cyc <= cyc + 1;

   initial begin
      #100000;
      n_errors++;
      results();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hwdata = 32'h0;
      i_pulse_start = 1'b0;
      i_smp_vld = 1'b0;
      i_smp = 6'h20;
      i_var_vld = 1'b0;
      i_var_term = 16'h0;
      n_errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(cdr_pkg::IDX_WIN, 16'h0000);
      rd(cdr_pkg::IDX_CTRL, 16'h0020);
      rd(cdr_pkg::IDX_VCTL, 16'h0000);
      rd(cdr_pkg::IDX_VDAT, 16'h0000);
      bus(1'b0, 32'h0000_0100, 16'h0);
      chk(rd_val, 32'h0);
      wr(cdr_pkg::IDX_PEAK, 16'hffff);
      rd(cdr_pkg::IDX_PEAK, 16'h0000);
      wr(cdr_pkg::IDX_WIN, 16'h0205);
      rd(cdr_pkg::IDX_WIN, 16'h0205);
      wr(cdr_pkg::IDX_CTRL, 16'hf028);
      shot({6'h3f, 6'h10, 6'h25, 6'h30, 6'h30, 6'h2a}, 16'h0028);
      rd(cdr_pkg::IDX_CTRL, 16'h0028);
      rd(cdr_pkg::IDX_PEAK, 16'h3003);
      rd(cdr_pkg::IDX_THR, 16'h0103);
      wr(cdr_pkg::IDX_CTRL, 16'h0098);
      shot({6'h00, 6'h3f, 6'h1c, 6'h20, 6'h19, 6'h19}, 16'h0098);
      rd(cdr_pkg::IDX_PEAK, 16'h1904);
      bus(1'b0, {24'h0, cdr_pkg::IDX_THR, 2'b00}, 16'h0);
      chk({8'h00, rd_val[31:8]}, 32'h0);
      for (int t = 0; t < 4; t++) begin
         wr(cdr_pkg::IDX_VCTL, 16'(2 * t + 1));
         t0 = cyc;
         wait_rdy();
         el = cyc - t0;
         chk(32'(el >= (t + 1) * 2 * PU && el <= (t + 1) * 2 * PU + 8),
             32'h1);
         rd(cdr_pkg::IDX_VDAT, 16'h0000);
         rd(cdr_pkg::IDX_VDAT, 16'h0000);
         rd(cdr_pkg::IDX_VCTL, 16'(2 * t + 1));
      end
      wr(cdr_pkg::IDX_TDAT, 16'h00ab);
      wr(cdr_pkg::IDX_VCTL, 16'h0001);
      wr(cdr_pkg::IDX_VCTL, 16'h0021);
      wr(cdr_pkg::IDX_TDAT, 16'h01cd);
      wr(cdr_pkg::IDX_VCTL, 16'h0011);
      @(posedge i_clk);
      i_var_vld  <= 1'b1;
      i_var_term <= 16'h1234;
      @(posedge i_clk);
      i_var_vld  <= 1'b0;
      wait_rdy();
      wr(cdr_pkg::IDX_VCTL, 16'h0009);
      repeat (45) @(posedge i_clk);
      rd(cdr_pkg::IDX_VDAT, 16'h1234);
      rd(cdr_pkg::IDX_VDAT, 16'habcd);
      rd(cdr_pkg::IDX_VCTL, 16'h0001);
      rd(cdr_pkg::IDX_VDAT, 16'h1234);
      results();
   end
endmodule // testbench

bind cdr_top cdr_top_asserts cdr_top_asserts_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hready(i_hready), .o_hrdata(o_hrdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .i_pulse_start(i_pulse_start));
